/* rtl/buck_ctrl_defines.vh */
// Constants for the buck regulator control register bank.
// Assumes a Verilog-2005 tool flow; included by its bare name.
`ifndef BUCK_CTRL_DEFINES_VH
`define BUCK_CTRL_DEFINES_VH

// Full register addresses (page-resolved, nine bits).
`define ADDR_CHAN_A_CTRL 9'h05D
`define ADDR_CHAN_B_CTRL 9'h05E
`define ADDR_PAGE_CTRL 9'h080
`define ADDR_CUR_LIMIT 9'h0D0
`define ADDR_LOCK_CTRL 9'h056
`define ADDR_POL_01 9'h058
`define ADDR_POL_23 9'h059
`define ADDR_POL_4 9'h05A
`define ADDR_LOCK_LO 9'h0D0
`define ADDR_LOCK_HI 9'h14F
`define ADDR_TOP 9'h17F

// Reset values.
`define RST_CHAN_CTRL 8'h00
`define RST_PAGE_CTRL 8'h00
`define RST_CUR_LIMIT 8'h99
`define RST_ZERO 8'h00

// Channel control field positions.
`define F_VPIN_HI 6
`define F_VPIN_LO 5
`define F_VSEL 4
`define F_PDOFF 3
`define F_EPIN_HI 2
`define F_EPIN_LO 1
`define F_ON 0
`define CTRL_RW_MASK 8'h7F

// Page control fields.
`define F_AUTO_RET 7
`define F_WMODE 6
`define F_PAGE_HI 2
`define F_PAGE_LO 0
`define PAGE_RW_MASK 8'hC7
`define PAGE_ZERO 3'h0

// Lock bit and polarity bit positions.
`define F_LOCK 7
`define F_POL_PIN0 2
`define F_POL_PIN1 6
`define F_POL_PIN2 2
`define F_POL_PIN3 6
`define F_POL_PIN4 2

// Pin assignment codes.
`define PIN_NONE 2'h0
`define PIN_C1 2'h1
`define PIN_C2 2'h2
`define PIN_C3 2'h3

// Serial interface selector.
`define IF_I2C 1'b0
`define IF_SPI 1'b1

`endif

/* rtl/buck_pin_edge.v */
// One channel's pin-driven enable and voltage-select edge logic.
// Assumes the pin levels are already synchronised to core_clk_i.
`timescale 1ns/1ps

module buck_pin_edge (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire [4:0] pins_i,
  input wire [4:0] pol_i,
  input wire [1:0] en_assign_i,
  input wire [1:0] volt_assign_i,
  output wire en_rise_o,
  output wire en_fall_o,
  output wire volt_rise_o,
  output wire volt_fall_o
);
`include "buck_ctrl_defines.vh"

  // Active-level view of each pin, with the polarity from the pin's own setting.
  // A pin is active when its level equals its polarity bit (1 = active high).
  wire [4:0] act = ~(pins_i ^ pol_i);
  reg [4:0] act_r; // Previous active level, for edge detection.
  reg en_act; // Active level of the pin chosen for enable.
  reg volt_act; // Active level of the pin chosen for voltage.
  reg en_prev; // Previous level of the chosen enable pin.
  reg volt_prev; // Previous level of the chosen voltage pin.

  // Enable pin map: 01 pin 0, 10 pin 1, 11 pin 3.
  always @* begin
    en_act = 1'b0;
    en_prev = 1'b0;
    case (en_assign_i)
      `PIN_C1: begin
        en_act = act[0];
        en_prev = act_r[0];
      end
      `PIN_C2: begin
        en_act = act[1];
        en_prev = act_r[1];
      end
      `PIN_C3: begin
        en_act = act[3];
        en_prev = act_r[3];
      end
      default: begin
        en_act = 1'b0;
        en_prev = 1'b0;
      end
    endcase
  end

  // Voltage pin map: 01 pin 1, 10 pin 2, 11 pin 4.
  always @* begin
    volt_act = 1'b0;
    volt_prev = 1'b0;
    case (volt_assign_i)
      `PIN_C1: begin
        volt_act = act[1];
        volt_prev = act_r[1];
      end
      `PIN_C2: begin
        volt_act = act[2];
        volt_prev = act_r[2];
      end
      `PIN_C3: begin
        volt_act = act[4];
        volt_prev = act_r[4];
      end
      default: begin
        volt_act = 1'b0;
        volt_prev = 1'b0;
      end
    endcase
  end

  // History of the active levels; tracked always so a newly chosen pin sees no false edge.
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // Pins and polarity bits reset to 0, so every pin starts active; a
      // history of all ones keeps a false edge from following reset.
      act_r <= 5'h1F;
    end else begin
      act_r <= act;
    end
  end

  // Edges are only reported while a pin is assigned.
  assign en_rise_o = (en_assign_i != `PIN_NONE) & en_act & ~en_prev;
  assign en_fall_o = (en_assign_i != `PIN_NONE) & ~en_act & en_prev;
  assign volt_rise_o = (volt_assign_i != `PIN_NONE) & volt_act & ~volt_prev;
  assign volt_fall_o = (volt_assign_i != `PIN_NONE) & ~volt_act & volt_prev;

endmodule // buck_pin_edge

/* rtl/buck_regulator_control_regs.v */
// Control register bank for two buck regulator channels, A and B.
// Assumes a serial front end decodes I2C or SPI into one-cycle read and
// write strobes with an 8-bit in-page address on core_clk_i.
//
// How it works
// - Voltage pin edges pick first or second setting.
// - Voltage pin code: none, pin1, pin2, pin4.
// - Pin polarity comes from pin's own setting.
// - Select bit chooses first or second voltage.
// - Pull-down connected when disabled unless bit set.
// - Enable pin edges turn channel on or off.
// - Enable pin code: none, pin0, pin1, pin3.
// - Auto-return clears page after each access.
// - Write-mode bit: page or repeated write.
// - I2C page maps low or upper register range.
// - SPI page maps three 128-register windows.
// - Current limit nibbles, 4000 mA plus 200 per step.
// - Lock bit blocks writes to 0xD0 through 0x14F.
`timescale 1ns/1ps

module buck_regulator_control_regs (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire if_sel_i,
  input wire wr_i,
  input wire rd_i,
  input wire access_done_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire [4:0] input_pins_i,
  output reg [7:0] rdata_o,
  output reg rvalid_o,
  output reg chan_a_on_o,
  output reg chan_b_on_o,
  output reg chan_a_volt_choice_o,
  output reg chan_b_volt_choice_o,
  output reg chan_a_pulldown_o,
  output reg chan_b_pulldown_o,
  output reg [3:0] chan_a_current_limit_o,
  output reg [3:0] chan_b_current_limit_o,
  output reg repeated_write_o
);
`include "buck_ctrl_defines.vh"

  reg [7:0] chan_a_control_r; // Channel A control.
  reg [7:0] chan_b_control_r; // Channel B control.
  reg [7:0] page_control_r; // Page select, write mode and auto-return.
  reg [7:0] current_limit_r; // Per-phase current limits, B high nibble.
  reg [7:0] lock_ctrl_r; // Holds the voltage lock bit.
  reg [7:0] pol_01_r; // Polarity settings for pins 0 and 1.
  reg [7:0] pol_23_r; // Polarity settings for pins 2 and 3.
  reg [7:0] pol_4_r; // Polarity setting for pin 4.
  reg [4:0] pin_meta_r; // First synchroniser stage, read only by the second.
  reg [4:0] pin_sync_r; // Second synchroniser stage.
  reg [8:0] full_addr; // Page-resolved register address.
  reg addr_ok; // Address falls in the exposed range.
  reg [7:0] rd_mux; // Read data before the output flop.
  wire [4:0] pol; // Active-high flags per pin.
  wire a_en_rise, a_en_fall, a_v_rise, a_v_fall;
  wire b_en_rise, b_en_fall, b_v_rise, b_v_fall;
  wire [2:0] page = page_control_r[`F_PAGE_HI:`F_PAGE_LO];
  wire locked = lock_ctrl_r[`F_LOCK];
  wire wr_ok;

  // Two-flop synchroniser for the asynchronous input pins.
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_meta_r <= 5'h00;
      pin_sync_r <= 5'h00;
    end else begin
      pin_meta_r <= input_pins_i;
      pin_sync_r <= pin_meta_r;
    end
  end

  // Polarity bits gathered from each pin's configuration register.
  assign pol = {pol_4_r[`F_POL_PIN4], pol_23_r[`F_POL_PIN3], pol_23_r[`F_POL_PIN2],
                pol_01_r[`F_POL_PIN1], pol_01_r[`F_POL_PIN0]};

  // Page resolution: I2C pages 00x/01x, SPI pages 000/001/010.
  always @* begin
    full_addr = 9'h000;
    addr_ok = 1'b0;
    if (if_sel_i == `IF_I2C) begin
      if (page[1] == 1'b0 && page[2] == 1'b0) begin
        full_addr = {1'b0, addr_i};
        addr_ok = 1'b1;
      end else if (page[2] == 1'b0) begin
        full_addr = {1'b1, addr_i};
        addr_ok = (full_addr <= `ADDR_TOP);
      end else begin
        full_addr = 9'h000;
        addr_ok = 1'b0;
      end
    end else begin
      case (page)
        3'h0: begin
          full_addr = {2'b00, addr_i[6:0]};
          addr_ok = ~addr_i[7];
        end
        3'h1: begin
          full_addr = {2'b01, addr_i[6:0]};
          addr_ok = ~addr_i[7];
        end
        3'h2: begin
          full_addr = {2'b10, addr_i[6:0]};
          addr_ok = ~addr_i[7];
        end
        default: begin
          // Higher pages are reserved; the access is simply dropped.
          full_addr = 9'h000;
          addr_ok = 1'b0;
        end
      endcase
    end
  end

  // Writes into the locked range are dropped while the lock bit is set.
  assign wr_ok = wr_i & addr_ok &
                 ~(locked & (full_addr >= `ADDR_LOCK_LO) & (full_addr <= `ADDR_LOCK_HI));

  // Read multiplexer; unmapped addresses read as zero.
  always @* begin
    rd_mux = `RST_ZERO;
    case (full_addr)
      `ADDR_CHAN_A_CTRL: rd_mux = chan_a_control_r;
      `ADDR_CHAN_B_CTRL: rd_mux = chan_b_control_r;
      `ADDR_PAGE_CTRL: rd_mux = page_control_r;
      `ADDR_CUR_LIMIT: rd_mux = current_limit_r;
      `ADDR_LOCK_CTRL: rd_mux = lock_ctrl_r;
      `ADDR_POL_01: rd_mux = pol_01_r;
      `ADDR_POL_23: rd_mux = pol_23_r;
      `ADDR_POL_4: rd_mux = pol_4_r;
      default: rd_mux = `RST_ZERO;
    endcase
    if (!addr_ok) begin
      rd_mux = `RST_ZERO;
    end
  end

  // Channel A pin event decoding.
  buck_pin_edge u_edge_a (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .pins_i(pin_sync_r),
    .pol_i(pol),
    .en_assign_i(chan_a_control_r[`F_EPIN_HI:`F_EPIN_LO]),
    .volt_assign_i(chan_a_control_r[`F_VPIN_HI:`F_VPIN_LO]),
    .en_rise_o(a_en_rise),
    .en_fall_o(a_en_fall),
    .volt_rise_o(a_v_rise),
    .volt_fall_o(a_v_fall)
  );

  // Channel B pin event decoding.
  buck_pin_edge u_edge_b (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .pins_i(pin_sync_r),
    .pol_i(pol),
    .en_assign_i(chan_b_control_r[`F_EPIN_HI:`F_EPIN_LO]),
    .volt_assign_i(chan_b_control_r[`F_VPIN_HI:`F_VPIN_LO]),
    .en_rise_o(b_en_rise),
    .en_fall_o(b_en_fall),
    .volt_rise_o(b_v_rise),
    .volt_fall_o(b_v_fall)
  );

  // Channel control registers. A pin edge in the same cycle as a host
  // write wins for the bit it touches, so the physical event is not lost.
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chan_a_control_r <= `RST_CHAN_CTRL;
      chan_b_control_r <= `RST_CHAN_CTRL;
    end else begin
      if (wr_ok && full_addr == `ADDR_CHAN_A_CTRL) begin
        chan_a_control_r <= wdata_i & `CTRL_RW_MASK;
      end
      if (wr_ok && full_addr == `ADDR_CHAN_B_CTRL) begin
        chan_b_control_r <= wdata_i & `CTRL_RW_MASK;
      end
      if (a_en_rise) begin
        chan_a_control_r[`F_ON] <= 1'b1;
      end else if (a_en_fall) begin
        chan_a_control_r[`F_ON] <= 1'b0;
      end
      if (b_en_rise) begin
        chan_b_control_r[`F_ON] <= 1'b1;
      end else if (b_en_fall) begin
        chan_b_control_r[`F_ON] <= 1'b0;
      end
      if (a_v_rise) begin
        chan_a_control_r[`F_VSEL] <= 1'b1;
      end else if (a_v_fall) begin
        chan_a_control_r[`F_VSEL] <= 1'b0;
      end
      if (b_v_rise) begin
        chan_b_control_r[`F_VSEL] <= 1'b1;
      end else if (b_v_fall) begin
        chan_b_control_r[`F_VSEL] <= 1'b0;
      end
    end
  end

  // Page control. Auto-return clears the page once the access is done;
  // a write to this register in that same cycle still takes its new page.
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      page_control_r <= `RST_PAGE_CTRL;
    end else if (wr_ok && full_addr == `ADDR_PAGE_CTRL) begin
      page_control_r <= wdata_i & `PAGE_RW_MASK;
    end else if (access_done_i && page_control_r[`F_AUTO_RET]) begin
      page_control_r[`F_PAGE_HI:`F_PAGE_LO] <= `PAGE_ZERO;
    end
  end

  // Remaining configuration registers: limits, lock and pin polarity.
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      current_limit_r <= `RST_CUR_LIMIT;
      lock_ctrl_r <= `RST_ZERO;
      pol_01_r <= `RST_ZERO;
      pol_23_r <= `RST_ZERO;
      pol_4_r <= `RST_ZERO;
    end else if (wr_ok) begin
      case (full_addr)
        `ADDR_CUR_LIMIT: current_limit_r <= wdata_i;
        `ADDR_LOCK_CTRL: lock_ctrl_r <= wdata_i;
        `ADDR_POL_01: pol_01_r <= wdata_i;
        `ADDR_POL_23: pol_23_r <= wdata_i;
        `ADDR_POL_4: pol_4_r <= wdata_i;
        default: lock_ctrl_r <= lock_ctrl_r;
      endcase
    end
  end

  // Registered outputs toward the regulator analog and the serial front end.
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= `RST_ZERO;
      rvalid_o <= 1'b0;
      chan_a_on_o <= 1'b0;
      chan_b_on_o <= 1'b0;
      chan_a_volt_choice_o <= 1'b0;
      chan_b_volt_choice_o <= 1'b0;
      chan_a_pulldown_o <= 1'b1;
      chan_b_pulldown_o <= 1'b1;
      chan_a_current_limit_o <= 4'h9;
      chan_b_current_limit_o <= 4'h9;
      repeated_write_o <= 1'b0;
    end else begin
      rvalid_o <= rd_i;
      if (rd_i) begin
        rdata_o <= rd_mux;
      end
      chan_a_on_o <= chan_a_control_r[`F_ON];
      chan_b_on_o <= chan_b_control_r[`F_ON];
      chan_a_volt_choice_o <= chan_a_control_r[`F_VSEL];
      chan_b_volt_choice_o <= chan_b_control_r[`F_VSEL];
      // Pull-down only while off, and only when not suppressed.
      chan_a_pulldown_o <= ~chan_a_control_r[`F_ON] & ~chan_a_control_r[`F_PDOFF];
      chan_b_pulldown_o <= ~chan_b_control_r[`F_ON] & ~chan_b_control_r[`F_PDOFF];
      // Code n means 4000 mA + 200 mA * n; the analog side scales it.
      chan_a_current_limit_o <= current_limit_r[3:0];
      chan_b_current_limit_o <= current_limit_r[7:4];
      repeated_write_o <= page_control_r[`F_WMODE];
    end
  end

endmodule // buck_regulator_control_regs

/* sim/buck_ctrl_assertions.sv */
// Port-level checks for the buck regulator control register bank.
// Assumes a bind to the top module: one clock, async active-low reset.
`timescale 1ns/1ps

module buck_ctrl_assertions (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire wr_i,
  input wire rd_i,
  input wire [4:0] input_pins_i,
  input wire rvalid_o,
  input wire chan_a_on_o,
  input wire chan_b_on_o,
  input wire chan_a_volt_choice_o,
  input wire chan_a_pulldown_o,
  input wire chan_b_pulldown_o,
  input wire [3:0] chan_a_current_limit_o,
  input wire repeated_write_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  reg [4:0] pins_r; // Pin levels one cycle back.
  reg [2:0] pin_age_r; // Cycles since a pin moved; saturates so it never wraps.

  // Track pin activity, since pin edges may legally move the channel outputs.
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pins_r <= 5'h00;
      pin_age_r <= 3'h7;
    end else begin
      pins_r <= input_pins_i;
      if (pins_r != input_pins_i) begin
        pin_age_r <= 3'h0;
      end else if (pin_age_r != 3'h7) begin
        pin_age_r <= pin_age_r + 3'h1;
      end
    end
  end

  // A read is answered on the very next edge.
  sequence rd_answer;
    ##1 rvalid_o;
  endsequence

  chk_read_answer: assert property (rd_i |-> rd_answer)
    else $error("read not answered after one cycle");
  chk_rvalid_cause: assert property (rvalid_o |-> $past(rd_i))
    else $error("read valid without a read");
  chk_pulldown_a_off: assert property (chan_a_on_o && $past(chan_a_on_o) |-> !chan_a_pulldown_o)
    else $error("channel a pull-down while enabled");
  chk_pulldown_b_off: assert property (chan_b_on_o && $past(chan_b_on_o) |-> !chan_b_pulldown_o)
    else $error("channel b pull-down while enabled");
  chk_enable_cause: assert property ($changed(chan_a_on_o) |-> $past(wr_i, 2) || pin_age_r <= 3'h5)
    else $error("channel a enable moved without cause");
  chk_volt_cause: assert property ($changed(chan_a_volt_choice_o) |-> $past(wr_i, 2) || pin_age_r <= 3'h5)
    else $error("channel a voltage choice moved without cause");
  chk_limit_cause: assert property ($changed(chan_a_current_limit_o) |-> $past(wr_i, 2))
    else $error("current limit moved without a write");
  chk_mode_cause: assert property ($changed(repeated_write_o) |-> $past(wr_i, 2))
    else $error("write mode moved without a write");
endmodule // buck_ctrl_assertions

bind buck_regulator_control_regs buck_ctrl_assertions i_buck_ctrl_assertions (.core_clk_i, .rst_n_i, .wr_i,
  .rd_i, .input_pins_i, .rvalid_o, .chan_a_on_o, .chan_b_on_o, .chan_a_volt_choice_o, .chan_a_pulldown_o,
  .chan_b_pulldown_o, .chan_a_current_limit_o, .repeated_write_o);

/* sim/buck_regulator_control_regs_test.sv */
// Self-checking bench for the buck regulator control register bank.
// Assumes host_model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked = samples_checked + 1; if ((g) !== (e)) begin \
  n_mismatch = n_mismatch + 1; $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module buck_regulator_control_regs_test;
  reg core_clk_i;
  reg rst_n_i;
  reg if_sel_i; // 0 selects I2C page decoding, 1 SPI.
  reg [4:0] pins;
  wire wr, rd, done, rvalid, a_on, b_on, a_v, b_v, a_pd, b_pd, rep;
  wire [7:0] addr, wdata, rdata;
  wire [3:0] a_lim, b_lim;
  reg [7:0] d;
  integer n_mismatch, samples_checked, cycles, i;

  buck_regulator_control_regs i_buck_regulator_control_regs (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .if_sel_i(if_sel_i), .wr_i(wr), .rd_i(rd), .access_done_i(done), .addr_i(addr), .wdata_i(wdata),
    .input_pins_i(pins), .rdata_o(rdata), .rvalid_o(rvalid), .chan_a_on_o(a_on), .chan_b_on_o(b_on),
    .chan_a_volt_choice_o(a_v), .chan_b_volt_choice_o(b_v), .chan_a_pulldown_o(a_pd),
    .chan_b_pulldown_o(b_pd), .chan_a_current_limit_o(a_lim), .chan_b_current_limit_o(b_lim),
    .repeated_write_o(rep));
  host_model i_host_model (.core_clk_i(core_clk_i), .rdata_i(rdata), .rvalid_i(rvalid), .wr_o(wr),
    .rd_o(rd), .done_o(done), .addr_o(addr), .wdata_o(wdata));

  // Free-running 125 MHz clock.
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end

  // Prints the verdict and stops; shared by the main flow and the timeout.
  task end_sim;
    begin
      if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  // A hang is cut off well past the two hundred or so cycles the flow needs.
  always @(posedge core_clk_i) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      n_mismatch = n_mismatch + 1;
      end_sim;
    end
  end

  task rdchk(input [7:0] a, input [7:0] e);
    begin
      i_host_model.rd_reg(a, d);
      `CHK("read data", e, d)
    end
  endtask

  // Write, then wait the two cycles until derived outputs follow.
  task wrs(input [7:0] a, input [7:0] v);
    begin
      i_host_model.wr_reg(a, v);
      repeat (2) @(posedge core_clk_i);
      #1;
    end
  endtask

  // Move one pin; six cycles cover synchroniser, edge and output stages.
  task pin(input integer n, input v);
    begin
      @(posedge core_clk_i);
      pins[n] <= v;
      repeat (6) @(posedge core_clk_i);
      #1;
    end
  endtask

  initial begin
    rst_n_i = 1'b0;
    if_sel_i = 1'b0;
    pins = 5'h00;
    n_mismatch = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (5) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    #1;
    `CHK("pulldown_a", 1'b1, a_pd)
    `CHK("limit_a", 4'h9, a_lim)
    `CHK("on_a", 1'b0, a_on)
    rdchk(8'hD0, 8'h99);
    wrs(8'h5D, 8'h01);
    `CHK("on_a", 1'b1, a_on)
    `CHK("pulldown_a", 1'b0, a_pd)
    wrs(8'h5D, 8'h08);
    `CHK("pulldown_a", 1'b0, a_pd)
    wrs(8'h5E, 8'h10);
    `CHK("volt_b", 1'b1, b_v)
    `CHK("pulldown_b", 1'b1, b_pd)
    wrs(8'hD0, 8'hF0);
    `CHK("limit_b", 4'hF, b_lim)
    `CHK("limit_a", 4'h0, a_lim)
    // Locked writes to the settings range must vanish without trace.
    i_host_model.wr_reg(8'h56, 8'h80);
    wrs(8'hD0, 8'h35);
    rdchk(8'hD0, 8'hF0);
    i_host_model.wr_reg(8'h56, 8'h00);
    wrs(8'h80, 8'h40);
    `CHK("repeat_mode", 1'b1, rep)
    // Upper page with auto-return armed; done brings the low page back.
    i_host_model.wr_reg(8'h80, 8'h82);
    rdchk(8'h5D, 8'h00);
    i_host_model.done_pulse;
    rdchk(8'h80, 8'h80);
    i_host_model.wr_reg(8'h80, 8'h81);
    rdchk(8'h5D, 8'h08);
    // The same page seen through SPI decoding: three 128-byte windows.
    @(posedge core_clk_i);
    if_sel_i <= 1'b1;
    rdchk(8'h50, 8'hF0);
    rdchk(8'h00, 8'h81);
    i_host_model.wr_reg(8'h00, 8'h82);
    rdchk(8'h5D, 8'h00);
    i_host_model.done_pulse;
    rdchk(8'h5D, 8'h08);
    @(posedge core_clk_i);
    if_sel_i <= 1'b0;
    // All pins active high; walk pin codes 1 to 3 of both fields.
    i_host_model.wr_reg(8'h58, 8'h44);
    i_host_model.wr_reg(8'h59, 8'h44);
    i_host_model.wr_reg(8'h5A, 8'h04);
    for (i = 1; i < 4; i = i + 1) begin
      i_host_model.wr_reg(8'h5D, {5'h00, i[1:0], 1'b0});
      i_host_model.wr_reg(8'h5E, {1'b0, i[1:0], 5'h00});
      pin((i == 3) ? 3 : i - 1, 1'b1);
      `CHK("on_a", 1'b1, a_on)
      pin((i == 3) ? 3 : i - 1, 1'b0);
      `CHK("on_a", 1'b0, a_on)
      pin((i == 3) ? 4 : i, 1'b1);
      `CHK("volt_b", 1'b1, b_v)
      pin((i == 3) ? 4 : i, 1'b0);
      `CHK("volt_b", 1'b0, b_v)
    end
    // Pin 0 made active low: its rise is a passive edge and turns off.
    i_host_model.wr_reg(8'h58, 8'h40);
    wrs(8'h5D, 8'h03);
    `CHK("on_a", 1'b1, a_on)
    pin(0, 1'b1);
    `CHK("on_a", 1'b0, a_on)
    // Channel A second voltage by register; channel B was never enabled.
    wrs(8'h5D, 8'h10);
    `CHK("volt_a", 1'b1, a_v)
    `CHK("on_a", 1'b0, a_on)
    `CHK("on_b", 1'b0, b_on)
    end_sim;
  end
endmodule // buck_regulator_control_regs_test

/* sim/host_model.sv */
// Host side of the bank: one-cycle read, write and access-done strobes.
// Assumes the bank samples strobes on the rising edge of core_clk_i.
`timescale 1ns/1ps

module host_model (
  input wire core_clk_i,
  input wire [7:0] rdata_i,
  input wire rvalid_i,
  output reg wr_o,
  output reg rd_o,
  output reg done_o,
  output reg [7:0] addr_o,
  output reg [7:0] wdata_o
);
  // Idle bus; released lines show the inverse so stale values never pass.
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    done_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end

  // One write strobe, held across exactly one sampling edge.
  task wr_reg(input [7:0] a, input [7:0] d);
    begin
      @(posedge core_clk_i);
      wr_o <= 1'b1;
      addr_o <= a;
      wdata_o <= d;
      @(posedge core_clk_i);
      wr_o <= 1'b0;
      addr_o <= ~a;
      wdata_o <= ~d;
    end
  endtask

  // One read; data without the valid flag comes back unknown on purpose.
  task rd_reg(input [7:0] a, output [7:0] d);
    begin
      @(posedge core_clk_i);
      rd_o <= 1'b1;
      addr_o <= a;
      @(posedge core_clk_i);
      rd_o <= 1'b0;
      addr_o <= ~a;
      #1;
      d = rvalid_i ? rdata_i : 8'hXX;
    end
  endtask

  // Marks the end of a serial access, which may return the page.
  task done_pulse;
    begin
      @(posedge core_clk_i);
      done_o <= 1'b1;
      @(posedge core_clk_i);
      done_o <= 1'b0;
    end
  endtask
endmodule // host_model
